// ===== design/qduc_pkg.sv
// constants and types for the quad dac update control block
// Functional notes
// [RULE1] valid frame loads addressed input register
// [RULE2] command 010 loads, then updates all
// [RULE3] command 110 loads load-mode from DB3..DB0
// [RULE4] load-mode low: dac register holds
// [RULE5] load-mode high: update at 24th fall
// [RULE6] load-mode bits reset to zero
// [RULE7] setup frame uses only DB21..DB19, DB3..DB0
// [RULE8] host sends msb first
// [RULE9] host lowers frame sync before data
// [RULE10] byte hosts keep sync low across bytes
// [RULE11] spi host uses polarity 0 phase 1; bench host and receiver work as phase 0
// [RULE12] host changes on fall, device samples rise
// [RULE13] setup frame changes only load-mode register
// [RULE14] frame: 2 ignored, command, address, data
// [RULE15] command codes decode per table
// [RULE16] address codes a..d and all
// [RULE17] early sync rise discards frame
package qduc_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_LAST = 5'h17;
    localparam int CMD_MSB = 21;
    localparam int CMD_LSB = 19;
    localparam int ADDR_MSB = 18;
    localparam int ADDR_LSB = 16;
    localparam int DATA_W = 16;
    localparam int NCH = 4;
    localparam logic [NCH-1:0] LOAD_MODE_RST = 4'h0;
    localparam logic [DATA_W-1:0] CODE_RST = 16'h0000;
    typedef enum logic [2:0] {
        QDUC_CMD_WRITE = 3'h0,
        QDUC_CMD_UPDATE = 3'h1,
        QDUC_CMD_WRITE_UPD_ALL = 3'h2,
        QDUC_CMD_WRITE_UPD = 3'h3,
        QDUC_CMD_POWER = 3'h4,
        QDUC_CMD_RESET = 3'h5,
        QDUC_CMD_LOAD_MODE = 3'h6,
        QDUC_CMD_RSVD = 3'h7
    } qduc_cmd_t;
    localparam logic [2:0] ADDR_ALL = 3'h7;
endpackage

// ===== design/qduc_chan.sv
// one channel: input register and dac register
`timescale 1ns/10ps
`default_nettype none
module qduc_chan (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic load_in,
    input wire logic update,
    input wire logic [qduc_pkg::DATA_W-1:0] code_in,
    output logic [qduc_pkg::DATA_W-1:0] input_code,
    output logic [qduc_pkg::DATA_W-1:0] dac_code
);
    import qduc_pkg::*;
    typedef struct packed {
        logic [DATA_W-1:0] inp;
        logic [DATA_W-1:0] dac;
    } qduc_chan_st_t;
    qduc_chan_st_t st_r, st_nxt;
    always_comb begin
        st_nxt = st_r;
        if (load_in) begin
            st_nxt.inp = code_in; // RULE1
        end
        // update takes the freshly loaded code in the same frame
        if (update) begin
            st_nxt.dac = load_in ? code_in : st_r.inp; // RULE4
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{inp: CODE_RST, dac: CODE_RST};
        end else begin
            st_r <= st_nxt;
        end
    end
    assign input_code = st_r.inp;
    assign dac_code = st_r.dac;
endmodule // qduc_chan
`default_nettype wire

// ===== design/qduc_top.sv
// serial frame receiver and update control for four channels
`timescale 1ns/10ps
`default_nettype none
module qduc_top (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic host_serial_clock,
    input wire logic frame_sync_n,
    input wire logic serial_data,
    output logic [qduc_pkg::NCH-1:0] load_update_control,
    output logic [qduc_pkg::DATA_W-1:0] input_code_a,
    output logic [qduc_pkg::DATA_W-1:0] input_code_b,
    output logic [qduc_pkg::DATA_W-1:0] input_code_c,
    output logic [qduc_pkg::DATA_W-1:0] input_code_d,
    output logic [qduc_pkg::DATA_W-1:0] dac_code_a,
    output logic [qduc_pkg::DATA_W-1:0] dac_code_b,
    output logic [qduc_pkg::DATA_W-1:0] dac_code_c,
    output logic [qduc_pkg::DATA_W-1:0] dac_code_d,
    output logic frame_done
);
    import qduc_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    typedef struct packed {
        logic sck_s1;
        logic sck_s2;
        logic sck_d;
        logic sync_s1;
        logic sync_s2;
        logic [FRAME_BITS-1:0] shift;
        logic [CNT_W-1:0] cnt;
        logic full;
        logic [NCH-1:0] load_mode;
        logic done;
    } qduc_st_t;
    qduc_st_t st_r, st_nxt;

    logic sck_rise, sck_fall, sync_low;
    logic [2:0] cmd_field;
    logic [2:0] channel_address_field;
    logic [DATA_W-1:0] code_field;
    logic [NCH-1:0] load_in, update;
    logic [DATA_W-1:0] inp_codes [NCH];
    logic [DATA_W-1:0] dac_codes [NCH];
    logic [NCH-1:0] sel;
    logic sdata_s1, sdata_s2;

    // ----------------------------------------
    // link edge detect
    // ----------------------------------------
    // the link clock is oversampled, so each of its phases must last
    // at least one sys_clk period or an edge can be lost
    assign sck_rise = st_r.sck_s2 && !st_r.sck_d;
    assign sck_fall = !st_r.sck_s2 && st_r.sck_d;
    assign sync_low = !st_r.sync_s2; // RULE9

    // ----------------------------------------
    // frame capture
    // ----------------------------------------
    logic [FRAME_BITS-1:0] frame;
    logic complete;
    always_comb begin
        st_nxt = st_r;
        st_nxt.sck_s1 = host_serial_clock;
        st_nxt.sck_s2 = st_r.sck_s1;
        st_nxt.sck_d = st_r.sck_s2;
        st_nxt.sync_s1 = frame_sync_n;
        st_nxt.sync_s2 = st_r.sync_s1;
        st_nxt.done = 1'b0;
        complete = 1'b0;
        frame = st_r.shift;
        if (!sync_low) begin
            // early rise drops the partial frame
            st_nxt.shift = '0; // RULE17
            st_nxt.cnt = '0;
            st_nxt.full = 1'b0;
        end else begin
            // edges past the 24th are ignored until sync rises
            if (sck_rise && !st_r.full) begin
                // msb arrives first, sampled on the rising edge
                st_nxt.shift = {st_r.shift[FRAME_BITS-2:0], st_r.sync_s2 ? 1'b0 : sdata_s2}; // RULE12
            end
            if (sck_fall && !st_r.full) begin
                if (st_r.cnt == FRAME_LAST) begin
                    complete = 1'b1; // RULE5
                    st_nxt.full = 1'b1;
                    st_nxt.done = 1'b1;
                    st_nxt.cnt = '0;
                end else begin
                    st_nxt.cnt = st_r.cnt + 5'h01;
                end
            end
        end
        if (complete && frame[CMD_MSB:CMD_LSB] == QDUC_CMD_LOAD_MODE) begin
            st_nxt.load_mode = frame[NCH-1:0]; // RULE3 RULE7
        end
    end

    // ----------------------------------------
    // data pin synchroniser
    // ----------------------------------------
    // kept apart so nothing reads its first stage
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sdata_s1 <= 1'b0;
            sdata_s2 <= 1'b0;
        end else begin
            sdata_s1 <= serial_data;
            sdata_s2 <= sdata_s1;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{
                sck_s1: 1'b0,
                sck_s2: 1'b0,
                sck_d: 1'b0,
                sync_s1: 1'b1,
                sync_s2: 1'b1,
                shift: 24'h000000,
                cnt: 5'h00,
                full: 1'b0,
                load_mode: LOAD_MODE_RST, // RULE6
                done: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    assign cmd_field = st_r.shift[CMD_MSB:CMD_LSB]; // RULE14
    assign channel_address_field = st_r.shift[ADDR_MSB:ADDR_LSB];
    assign code_field = st_r.shift[DATA_W-1:0];

    // channel select from the address field, one-hot except 111 which selects all four;
    // address codes 100 to 110 are reserved and select nothing
    always_comb begin
        sel = '0;
        unique case (channel_address_field) // RULE16
            3'h0: sel = 4'h1;
            3'h1: sel = 4'h2;
            3'h2: sel = 4'h4;
            3'h3: sel = 4'h8;
            ADDR_ALL: sel = 4'hf;
            default: sel = '0;
        endcase
    end

    always_comb begin
        load_in = '0;
        update = '0;
        if (complete) begin
            unique case (cmd_field) // RULE15
                QDUC_CMD_WRITE: begin
                    load_in = sel;
                end
                QDUC_CMD_UPDATE: begin
                    update = sel;
                end
                QDUC_CMD_WRITE_UPD_ALL: begin
                    load_in = sel;
                    update = 4'hf; // RULE2
                end
                QDUC_CMD_WRITE_UPD: begin
                    load_in = sel;
                    update = sel;
                end
                // power and reset are not carried out here; setup frames touch
                // no code register, reserved frames still update auto channels
                QDUC_CMD_POWER, QDUC_CMD_RESET, QDUC_CMD_LOAD_MODE, QDUC_CMD_RSVD: begin
                    load_in = '0; // RULE13
                end
            endcase
            // auto-update channels follow every valid frame except a mode
            // setup, which must leave every code register as it stands
            if (cmd_field != QDUC_CMD_LOAD_MODE) begin
                update = update | st_r.load_mode; // RULE5 RULE4 RULE13
            end
        end
    end

    // ----------------------------------------
    // channel registers
    // ----------------------------------------
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        qduc_chan u_chan (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .load_in(load_in[i]),
            .update(update[i]),
            .code_in(code_field),
            .input_code(inp_codes[i]),
            .dac_code(dac_codes[i])
        );
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign load_update_control = st_r.load_mode;
    // one-cycle strobe, one cycle after the 24th fall is seen
    assign frame_done = st_r.done;
    assign input_code_a = inp_codes[0];
    assign input_code_b = inp_codes[1];
    assign input_code_c = inp_codes[2];
    assign input_code_d = inp_codes[3];
    // dac codes leave straight from their registers
    assign dac_code_a = dac_codes[0];
    assign dac_code_b = dac_codes[1];
    assign dac_code_c = dac_codes[2];
    assign dac_code_d = dac_codes[3];
endmodule // qduc_top
`default_nettype wire

// ===== tb/qduc_assertions.sv
// port checker for the quad dac update control block
`timescale 1ns/10ps
`default_nettype none
module qduc_assertions (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic frame_sync_n,
    input wire logic [qduc_pkg::NCH-1:0] load_update_control,
    input wire logic [qduc_pkg::DATA_W-1:0] input_code_a,
    input wire logic [qduc_pkg::DATA_W-1:0] input_code_d,
    input wire logic [qduc_pkg::DATA_W-1:0] dac_code_a,
    input wire logic [qduc_pkg::DATA_W-1:0] dac_code_d,
    input wire logic frame_done
);
    import qduc_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_done_pulse; frame_done |=> !frame_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_in_chg; $changed({input_code_a, input_code_d}) |-> ##[0:1] frame_done; endproperty
    a_in_chg: assert property (p_in_chg) else $error("input code moved");
    property p_dac_chg; $changed({dac_code_a, dac_code_d}) |-> ##[0:1] frame_done; endproperty
    a_dac_chg: assert property (p_dac_chg) else $error("dac code moved");
    property p_mode_chg; $changed(load_update_control) |-> ##[0:1] frame_done; endproperty
    a_mode_chg: assert property (p_mode_chg) else $error("mode moved");
    // mode held three cycles back rules out the frame that set it
    property p_auto_a; frame_done && load_update_control[0] && $past(load_update_control[0], 3)
        |-> dac_code_a == input_code_a; endproperty
    a_auto_a: assert property (p_auto_a) else $error("auto a missed");
    property p_auto_d; frame_done && load_update_control[3] && $past(load_update_control[3], 3)
        |-> dac_code_d == input_code_d; endproperty
    a_auto_d: assert property (p_auto_d) else $error("auto d missed");
    property p_rst; $rose(arst_n) |-> load_update_control == '0 && dac_code_a == '0; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_quiet; frame_sync_n [*8] |-> !frame_done; endproperty
    a_quiet: assert property (p_quiet) else $error("done while idle");
    property p_done_sync; frame_done |-> !$past(frame_sync_n, 8); endproperty
    a_done_sync: assert property (p_done_sync) else $error("done without sync");
endmodule // qduc_assertions
bind qduc_top qduc_assertions i_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .frame_sync_n(frame_sync_n), .load_update_control(load_update_control),
    .input_code_a(input_code_a), .input_code_d(input_code_d), .dac_code_a(dac_code_a),
    .dac_code_d(dac_code_d), .frame_done(frame_done));
`default_nettype wire

// ===== tb/qduc_host_model.sv
// host serial port model sending frames to the block
`timescale 1ns/10ps
`default_nettype none
module qduc_host_model (
    input wire logic sys_clk,
    output logic host_serial_clock,
    output logic frame_sync_n,
    output logic serial_data
);
    initial begin
        host_serial_clock = 1'b0;
        frame_sync_n = 1'b1;
        serial_data = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // fewer than 24 bits raises sync early; slow stretches each half period
    task automatic send(input logic [23:0] f, input int nbits, input int slow);
        frame_sync_n <= 1'b0;
        for (int i = 23; i > 23 - nbits; i--) begin
            serial_data <= f[i];
            tick(4 + slow);
            host_serial_clock <= 1'b1;
            tick(4 + slow);
            host_serial_clock <= 1'b0;
            if (i == 16 || i == 8) tick(6);
        end
        tick(4);
        serial_data <= ~serial_data;
        frame_sync_n <= 1'b1;
        tick(12);
    endtask
endmodule // qduc_host_model
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the quad dac update control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import qduc_pkg::*;
    logic sys_clk, arst_n, sclk, sync_n, sdata, frame_done;
    logic [NCH-1:0] load_update_control;
    logic [NCH-1:0] mode_e = '0;
    logic [DATA_W-1:0] input_code_a, input_code_b, input_code_c, input_code_d;
    logic [DATA_W-1:0] dac_code_a, dac_code_b, dac_code_c, dac_code_d;
    logic [DATA_W-1:0] ine[4] = '{default: '0};
    logic [DATA_W-1:0] dace[4] = '{default: '0};
    int miscompares = 0;
    int comparisons = 0;
    int done_seen = 0;
    always @(posedge sys_clk) begin
        if (frame_done === 1'b1) done_seen++;
    end
    qduc_top i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .host_serial_clock(sclk),
        .frame_sync_n(sync_n), .serial_data(sdata), .load_update_control(load_update_control),
        .input_code_a(input_code_a), .input_code_b(input_code_b), .input_code_c(input_code_c),
        .input_code_d(input_code_d), .dac_code_a(dac_code_a), .dac_code_b(dac_code_b),
        .dac_code_c(dac_code_c), .dac_code_d(dac_code_d), .frame_done(frame_done));
    qduc_host_model i_host (.sys_clk(sys_clk), .host_serial_clock(sclk),
        .frame_sync_n(sync_n), .serial_data(sdata));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_all();
        logic [DATA_W-1:0] si[4];
        logic [DATA_W-1:0] sd[4];
        si = '{input_code_a, input_code_b, input_code_c, input_code_d};
        sd = '{dac_code_a, dac_code_b, dac_code_c, dac_code_d};
        for (int k = 0; k < 4; k++) begin
            chk("input", ine[k], si[k]);
            chk("dac", dace[k], sd[k]);
        end
        chk("mode", 16'(mode_e), 16'(load_update_control));
    endtask
    // expected state moves only for whole frames; mode used is the one before the frame
    task automatic do_frame(input logic [2:0] c, input logic [2:0] a, input logic [15:0] d,
        input int n, input int slow);
        logic [3:0] m;
        int d0;
        m = mode_e;
        d0 = done_seen;
        i_host.send({2'b10, c, a, d}, n, slow);
        chk("done", 16'(n == 24), 16'(done_seen - d0));
        // a setup frame moves no code, even on auto channels
        for (int k = 0; k < 4 && n == 24; k++) begin
            if ((a == k || a == 3'h7) && c inside {3'h0, 3'h2, 3'h3}) ine[k] = d;
            if (c == 3'h2 || (m[k] && c != 3'h6) ||
                ((a == k || a == 3'h7) && c inside {3'h1, 3'h3}))
                dace[k] = ine[k];
        end
        if (n == 24 && c == 3'h6) mode_e = d[3:0];
        check_all();
    endtask
    task automatic s_write();
        do_frame(3'h0, 3'h7, 16'h0f0f, 24, 0);
        do_frame(3'h0, 3'h0, 16'h1234, 24, 0);
        do_frame(3'h0, 3'h1, 16'h5678, 24, 0);
        do_frame(3'h0, 3'h4, 16'hffff, 24, 0);
    endtask
    task automatic s_updates();
        do_frame(3'h1, 3'h1, ine[1], 24, 0);
        do_frame(3'h3, 3'h2, 16'hbeef, 24, 0);
        do_frame(3'h2, 3'h3, 16'hc0de, 24, 0);
    endtask
    task automatic s_mode();
        do_frame(3'h6, 3'h5, 16'hfff9, 24, 0);
        do_frame(3'h0, 3'h0, 16'h4321, 24, 3);
        do_frame(3'h0, 3'h1, 16'h8765, 24, 0);
        do_frame(3'h0, 3'h0, 16'h0001, 23, 0);
        do_frame(3'h4, 3'h0, 16'h0000, 24, 0);
        do_frame(3'h5, 3'h0, 16'h0000, 24, 0);
        do_frame(3'h7, 3'h0, 16'h0000, 24, 0);
        do_frame(3'h6, 3'h0, 16'h0002, 24, 0);
        do_frame(3'h6, 3'h7, 16'h0000, 24, 0);
    endtask
    task automatic close_out();
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check_all();
        s_write();
        s_updates();
        s_mode();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        close_out();
    end
endmodule // testbench
`default_nettype wire
